/* File: core/ppdar_top.sv */
module ppdar_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic ser_en,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  input wire logic cal_request,
  input wire logic osc_link_request,
  input wire logic detector_raise_in,
  input wire logic detector_lower_in,
  output logic [6:0] pump_sink_gain,
  output logic [6:0] pump_source_gain,
  output logic [6:0] leak_magnitude,
  output logic leak_source_on,
  output logic leak_sink_on,
  output logic cal_self_test,
  output logic [2:0] detector_reset_delay_sel,
  output logic [1:0] slip_guard_threshold,
  output logic pump_raise,
  output logic pump_lower,
  output logic slip_boost,
  output logic cal_busy,
  output logic cal_done,
  output logic osc_link_strobe,
  output logic osc_link_dropped,
  output logic cal_clock_too_fast
);
  import ppdar_pkg::*;

  localparam int PINS = 7;

  ppdar_cfg_if cfg ();

  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_s;
  logic sck_s, en_s, din_s, calreq_s, linkreq_s, raise_s, lower_s;
  logic sck_q, next_sck_q;
  logic en_q, next_en_q;
  logic calreq_q, next_calreq_q;
  logic linkreq_q, next_linkreq_q;

  logic [30:0] shift_in, next_shift_in;
  logic [5:0] bit_cnt, next_bit_cnt;
  logic read_mode, next_read_mode;
  logic [23:0] out_shift, next_out_shift;
  logic dout, next_dout;
  logic dout_oe, next_dout_oe;
  logic [23:0] pump_reg, next_pump_reg;
  logic [23:0] autocal_reg, next_autocal_reg;
  logic [23:0] detector_reg, next_detector_reg;

  logic sck_rise, sck_fall, en_fall;
  logic [5:0] rd_addr;
  logic [5:0] wr_addr;

  // 0 means unmapped; 1..3 select the three configuration words
  function automatic logic [1:0] reg_select(input logic [5:0] addr);
    if (addr == PUMP_OFFSET) begin
      return 2'd1;
    end else if (addr == AUTOCAL_OFFSET) begin
      return 2'd2;
    end else if (addr == DETECTOR_OFFSET) begin
      return 2'd3;
    end
    return 2'd0;
  endfunction

  assign pin_raw = {detector_lower_in, detector_raise_in, osc_link_request, cal_request,
                    ser_din, ser_en, ser_clk};

  // all pins cross in through two flops before any logic looks at them
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_meta[g] <= 1'b0;
          pin_s[g] <= 1'b0;
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_s[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  assign sck_s = pin_s[0];
  assign en_s = pin_s[1];
  assign din_s = pin_s[2];
  assign calreq_s = pin_s[3];
  assign linkreq_s = pin_s[4];
  assign raise_s = pin_s[5];
  assign lower_s = pin_s[6];

  always_comb begin
    next_sck_q = sck_s;
    next_en_q = en_s;
    next_calreq_q = calreq_s;
    next_linkreq_q = linkreq_s;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_q <= 1'b0;
      en_q <= 1'b0;
      calreq_q <= 1'b0;
      linkreq_q <= 1'b0;
    end else begin
      sck_q <= next_sck_q;
      en_q <= next_en_q;
      calreq_q <= next_calreq_q;
      linkreq_q <= next_linkreq_q;
    end
  end

  assign sck_rise = sck_s && !sck_q;
  assign sck_fall = !sck_s && sck_q;
  assign en_fall = !en_s && en_q;
  assign rd_addr = {shift_in[4:0], din_s};
  assign wr_addr = shift_in[29:24];

  // frame: read flag, six address bits, 24 data bits, msb first
  always_comb begin
    next_shift_in = shift_in;
    next_bit_cnt = bit_cnt;
    next_read_mode = read_mode;
    next_out_shift = out_shift;
    next_dout = dout;
    next_dout_oe = 1'b0;
    next_pump_reg = pump_reg;
    next_autocal_reg = autocal_reg;
    next_detector_reg = detector_reg;
    if (en_s) begin
      next_dout_oe = read_mode;
      if (sck_rise && bit_cnt < 6'(FRAME_BITS)) begin
        next_shift_in = {shift_in[29:0], din_s};
        next_bit_cnt = bit_cnt + 6'h01;
        if (bit_cnt == 6'(ADDR_DONE_BITS - 1)) begin
          next_read_mode = shift_in[5];
          // unmapped reads shift out zeros
          unique case (reg_select(rd_addr))
            2'd1: next_out_shift = pump_reg;
            2'd2: next_out_shift = autocal_reg;
            2'd3: next_out_shift = detector_reg;
            default: next_out_shift = 24'h00_0000;
          endcase
        end
      end
      if (sck_fall && read_mode) begin
        next_dout = out_shift[23];
        next_out_shift = {out_shift[22:0], 1'b0};
      end
    end else begin
      next_bit_cnt = 6'h00;
      next_read_mode = 1'b0;
      next_dout = 1'b0;
    end
    // short frames are dropped whole, long ones keep their first 31 bits; reserved bits store as written
    if (en_fall && bit_cnt == 6'(FRAME_BITS) && !shift_in[30]) begin
      unique case (reg_select(wr_addr))
        2'd1: next_pump_reg = shift_in[23:0];
        2'd2: next_autocal_reg = shift_in[23:0];
        2'd3: next_detector_reg = shift_in[23:0];
        default: next_pump_reg = pump_reg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_in <= 31'h0000_0000;
      bit_cnt <= 6'h00;
      read_mode <= 1'b0;
      out_shift <= 24'h00_0000;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      pump_reg <= PUMP_RESET;
      autocal_reg <= AUTOCAL_RESET;
      detector_reg <= DETECTOR_RESET;
    end else begin
      shift_in <= next_shift_in;
      bit_cnt <= next_bit_cnt;
      read_mode <= next_read_mode;
      out_shift <= next_out_shift;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      pump_reg <= next_pump_reg;
      autocal_reg <= next_autocal_reg;
      detector_reg <= next_detector_reg;
    end
  end

  assign cfg.pump = pump_reg;
  assign cfg.autocal = autocal_reg;
  assign cfg.detector = detector_reg;

  assign ser_dout = dout;
  assign ser_dout_oe = dout_oe;

  assign pump_sink_gain = pump_reg[SINK_GAIN_LSB +: 7];
  assign pump_source_gain = pump_reg[SOURCE_GAIN_LSB +: 7];
  assign leak_magnitude = pump_reg[LEAK_MAG_LSB +: 7];
  // direction bits are passed as written; software picks upward leakage
  assign leak_source_on = pump_reg[LEAK_SOURCE_BIT];
  assign leak_sink_on = pump_reg[LEAK_SINK_BIT];
  assign cal_self_test = autocal_reg[SELF_TEST_BIT];
  assign detector_reset_delay_sel = detector_reg[DELAY_SEL_LSB +: 3];
  assign slip_guard_threshold = detector_reg[SLIP_LSB +: 2];

  ppdar_cal u_cal (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg(cfg.user),
    .cal_start(calreq_s && !calreq_q),
    .link_request(linkreq_s && !linkreq_q),
    .cal_busy(cal_busy),
    .cal_done(cal_done),
    .link_strobe(osc_link_strobe),
    .link_dropped(osc_link_dropped),
    .clock_too_fast(cal_clock_too_fast)
  );

  ppdar_detector u_detector (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg(cfg.user),
    .raise_in(raise_s),
    .lower_in(lower_s),
    .pump_raise(pump_raise),
    .pump_lower(pump_lower),
    .slip_boost(slip_boost)
  );
endmodule

/* File: core/ppdar_pkg.sv */
package ppdar_pkg;
  localparam int REG_W = 24;
  localparam int ADDR_W = 6;
  localparam int FRAME_BITS = 31;
  localparam int ADDR_DONE_BITS = 7;

  localparam logic [5:0] PUMP_OFFSET = 6'h09;
  localparam logic [5:0] AUTOCAL_OFFSET = 6'h0a;
  localparam logic [5:0] DETECTOR_OFFSET = 6'h0b;

  localparam logic [23:0] PUMP_RESET = 24'h40_3264;
  localparam logic [23:0] AUTOCAL_RESET = 24'h00_2205;
  localparam logic [23:0] DETECTOR_RESET = 24'h0f_8061;

  localparam int SINK_GAIN_LSB = 0;
  localparam int SOURCE_GAIN_LSB = 7;
  localparam int LEAK_MAG_LSB = 14;
  localparam int LEAK_SOURCE_BIT = 21;
  localparam int LEAK_SINK_BIT = 22;
  localparam int TUNE_RES_LSB = 0;
  localparam int CAL_SKIP_BIT = 11;
  localparam int LINK_INHIBIT_BIT = 12;
  localparam int CAL_DIV_LSB = 13;
  localparam int SELF_TEST_BIT = 15;
  localparam int DELAY_SEL_LSB = 0;
  localparam int RAISE_ON_BIT = 5;
  localparam int LOWER_ON_BIT = 6;
  localparam int SLIP_LSB = 7;
  localparam int SOURCE_FORCE_BIT = 9;
  localparam int SINK_FORCE_BIT = 10;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int CAL_CLK_MAX_KHZ = 50000;
  localparam int CLK_KHZ = 200000;
  localparam int SLIP_T1_PS = 5400;
  localparam int SLIP_T2_PS = 14400;
  localparam int SLIP_T3_PS = 24100;
  localparam logic [2:0] SLIP_C1 = 3'((SLIP_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [2:0] SLIP_C2 = 3'((SLIP_T2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [2:0] SLIP_C3 = 3'((SLIP_T3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam logic [5:0] DIV_BY_1 = 6'h01;
  localparam logic [5:0] DIV_BY_4 = 6'h04;
  localparam logic [5:0] DIV_BY_16 = 6'h10;
  localparam logic [5:0] DIV_BY_32 = 6'h20;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_MEASURE = 3'b010,
    CAL_FINISH = 3'b100
  } ppdar_cal_state_t;
endpackage

/* File: core/ppdar_cfg_if.sv */
interface ppdar_cfg_if;
  logic [23:0] pump;
  logic [23:0] autocal;
  logic [23:0] detector;
  modport owner (output pump, output autocal, output detector);
  modport user (input pump, input autocal, input detector);
endinterface

/* File: core/ppdar_cal.sv */
module ppdar_cal (
  input wire logic clk,
  input wire logic sys_rst,
  ppdar_cfg_if.user cfg,
  input wire logic cal_start,
  input wire logic link_request,
  output logic cal_busy,
  output logic cal_done,
  output logic link_strobe,
  output logic link_dropped,
  output logic clock_too_fast
);
  import ppdar_pkg::*;

  ppdar_cal_state_t state, next_state;
  logic [5:0] div_cnt, next_div_cnt;
  logic [8:0] meas_cnt, next_meas_cnt;
  logic link_pending, next_link_pending;
  logic done, next_done;
  logic strobe, next_strobe;
  logic dropped, next_dropped;
  logic [5:0] div_ratio;
  logic [8:0] meas_len;
  logic tick;

  always_comb begin
    unique case (cfg.autocal[CAL_DIV_LSB +: 2])
      2'd0: div_ratio = DIV_BY_1;
      2'd1: div_ratio = DIV_BY_4;
      2'd2: div_ratio = DIV_BY_16;
      default: div_ratio = DIV_BY_32;
    endcase
    unique case (cfg.autocal[TUNE_RES_LSB +: 3])
      3'd0: meas_len = 9'h001;
      3'd1: meas_len = 9'h002;
      3'd2: meas_len = 9'h004;
      3'd3: meas_len = 9'h008;
      3'd4: meas_len = 9'h020;
      3'd5: meas_len = 9'h040;
      3'd6: meas_len = 9'h080;
      default: meas_len = 9'h100;
    endcase
  end

  // tick is one period of the divided calibration clock; >= lets a shorter
  // ratio take effect at once instead of running the counter round to zero
  assign tick = (div_cnt >= div_ratio - 6'h01);
  // divided rate above the ceiling is flagged, not corrected
  assign clock_too_fast = (CLK_KHZ / int'(div_ratio)) > CAL_CLK_MAX_KHZ;

  always_comb begin
    next_div_cnt = tick ? 6'h00 : div_cnt + 6'h01;
    next_state = state;
    next_meas_cnt = meas_cnt;
    next_done = 1'b0;
    unique case (state)
      CAL_IDLE: begin
        if (cal_start && !cfg.autocal[CAL_SKIP_BIT]) begin
          next_state = CAL_MEASURE;
          next_meas_cnt = 9'h000;
        end
      end
      CAL_MEASURE: begin
        if (tick) begin
          next_meas_cnt = meas_cnt + 9'h001;
          if (meas_cnt + 9'h001 == meas_len) begin
            next_state = CAL_FINISH;
          end
        end
      end
      CAL_FINISH: begin
        next_done = 1'b1;
        next_state = CAL_IDLE;
      end
    endcase
    // a request in the release cycle stays pending
    next_link_pending = (link_pending && !tick) ||
      (link_request && !cfg.autocal[LINK_INHIBIT_BIT]);
    next_strobe = link_pending && tick;
    next_dropped = link_request && cfg.autocal[LINK_INHIBIT_BIT];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CAL_IDLE;
      div_cnt <= 6'h00;
      meas_cnt <= 9'h000;
      link_pending <= 1'b0;
      done <= 1'b0;
      strobe <= 1'b0;
      dropped <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      meas_cnt <= next_meas_cnt;
      link_pending <= next_link_pending;
      done <= next_done;
      strobe <= next_strobe;
      dropped <= next_dropped;
    end
  end

  assign cal_busy = (state != CAL_IDLE);
  assign cal_done = done;
  assign link_strobe = strobe;
  assign link_dropped = dropped;
endmodule

/* File: core/ppdar_detector.sv */
module ppdar_detector (
  input wire logic clk,
  input wire logic sys_rst,
  ppdar_cfg_if.user cfg,
  input wire logic raise_in,
  input wire logic lower_in,
  output logic pump_raise,
  output logic pump_lower,
  output logic slip_boost
);
  import ppdar_pkg::*;

  logic raise, next_raise;
  logic lower, next_lower;
  logic boost, next_boost;
  logic [2:0] err_cnt, next_err_cnt;
  logic [2:0] limit;

  always_comb begin
    unique case (cfg.detector[SLIP_LSB +: 2])
      2'd0: limit = 3'h0;
      2'd1: limit = SLIP_C1;
      2'd2: limit = SLIP_C2;
      default: limit = SLIP_C3;
    endcase
  end

  always_comb begin
    next_raise = (raise_in && cfg.detector[RAISE_ON_BIT])
      || cfg.detector[SOURCE_FORCE_BIT];
    next_lower = (lower_in && cfg.detector[LOWER_ON_BIT])
      || cfg.detector[SINK_FORCE_BIT];
    // phase error measured as cycles with only one side active
    if (raise_in ^ lower_in) begin
      next_err_cnt = (err_cnt == 3'h7) ? err_cnt : err_cnt + 3'h1;
    end else begin
      next_err_cnt = 3'h0;
    end
    next_boost = (limit != 3'h0) && (next_err_cnt > limit);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      raise <= 1'b0;
      lower <= 1'b0;
      boost <= 1'b0;
      err_cnt <= 3'h0;
    end else begin
      raise <= next_raise;
      lower <= next_lower;
      boost <= next_boost;
      err_cnt <= next_err_cnt;
    end
  end

  assign pump_raise = raise;
  assign pump_lower = lower;
  assign slip_boost = boost;
endmodule

/* File: verification/ppdar_checker.sv */
module ppdar_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ser_en,
  input wire logic ser_dout,
  input wire logic ser_dout_oe,
  input wire logic [6:0] pump_sink_gain,
  input wire logic [1:0] slip_guard_threshold,
  input wire logic slip_boost,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire logic osc_link_strobe,
  input wire logic osc_link_dropped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // longest run is 256 ticks of clk/32 plus the finishing cycles
  logic [13:0] busy_cnt;
  logic [13:0] next_busy_cnt;
  always_comb next_busy_cnt = cal_busy ? busy_cnt + 14'h0001 : 14'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busy_cnt <= 14'h0000;
    else busy_cnt <= next_busy_cnt;
  end
  sequence bus_quiet;
    !ser_en [*8];
  endsequence
  sequence guard_off;
    (slip_guard_threshold == 2'h0) [*2];
  endsequence
  a_done_one_cycle: assert property (cal_done |=> !cal_done)
    else $error("cal_done wider than one cycle");
  a_done_after_busy: assert property (cal_done |-> $past(cal_busy))
    else $error("cal_done without busy phase");
  a_busy_bounded: assert property (busy_cnt <= 14'h2010)
    else $error("calibration runs too long");
  a_strobe_one_cycle: assert property (osc_link_strobe |=> !osc_link_strobe)
    else $error("link strobe wider than one cycle");
  a_link_exclusive: assert property (!(osc_link_strobe && osc_link_dropped))
    else $error("link strobe and drop together");
  a_slip_code_off: assert property (guard_off |-> !slip_boost)
    else $error("slip boost while guard disabled");
  a_dout_needs_oe: assert property (ser_dout |-> ser_dout_oe)
    else $error("read data without output enable");
  a_oe_frame_end: assert property (!ser_en [*5] |-> !ser_dout_oe)
    else $error("output enable outside frame");
  a_fields_stable: assert property (bus_quiet |=> $stable(pump_sink_gain))
    else $error("gain field moved without a frame");
endmodule

bind ppdar_top ppdar_checker u_chk (.clk(clk), .sys_rst(sys_rst), .ser_en(ser_en),
  .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .pump_sink_gain(pump_sink_gain),
  .slip_guard_threshold(slip_guard_threshold), .slip_boost(slip_boost), .cal_busy(cal_busy),
  .cal_done(cal_done), .osc_link_strobe(osc_link_strobe), .osc_link_dropped(osc_link_dropped));

/* File: verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppdar_pkg::*;
  logic clk, sys_rst, ser_clk, ser_en, ser_din, ser_dout, ser_dout_oe;
  logic cal_request, osc_link_request, detector_raise_in, detector_lower_in;
  logic [6:0] pump_sink_gain, pump_source_gain, leak_magnitude;
  logic leak_source_on, leak_sink_on, cal_self_test, pump_raise, pump_lower, slip_boost;
  logic cal_busy, cal_done, osc_link_strobe, osc_link_dropped, cal_clock_too_fast;
  logic [2:0] detector_reset_delay_sel;
  logic [1:0] slip_guard_threshold;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_c291;
  logic [23:0] regs [3];
  int tl [8] = '{1, 2, 4, 8, 32, 64, 128, 256};
  int dv [4] = '{1, 4, 16, 32};
  int cal_t [4] = '{0, 3, 5, 7};
  int sl [4] = '{0, SLIP_C1, SLIP_C2, SLIP_C3};

  ppdar_top u_ppdar_top (.clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_en(ser_en),
    .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .cal_request(cal_request), .osc_link_request(osc_link_request),
    .detector_raise_in(detector_raise_in), .detector_lower_in(detector_lower_in),
    .pump_sink_gain(pump_sink_gain), .pump_source_gain(pump_source_gain),
    .leak_magnitude(leak_magnitude), .leak_source_on(leak_source_on),
    .leak_sink_on(leak_sink_on), .cal_self_test(cal_self_test),
    .detector_reset_delay_sel(detector_reset_delay_sel),
    .slip_guard_threshold(slip_guard_threshold), .pump_raise(pump_raise),
    .pump_lower(pump_lower), .slip_boost(slip_boost), .cal_busy(cal_busy),
    .cal_done(cal_done), .osc_link_strobe(osc_link_strobe),
    .osc_link_dropped(osc_link_dropped), .cal_clock_too_fast(cal_clock_too_fast));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // latest cal_done edge: sync, edge detect and finish add 4 to the ticks
  function automatic int exp_cal(input int t, input int d);
    return tl[t] * dv[d] + 4;
  endfunction

  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // halves of 6 cycles leave room for the 2-flop sync and the read latency
  task automatic frame(input logic rw, input logic [5:0] a, input logic [23:0] wd,
                       output logic [23:0] rd);
    logic [30:0] f;
    f = {rw, a, wd};
    rd = 24'h00_0000;
    ser_en = 1'b1;
    cyc(6);
    for (int i = 30; i >= 0; i--) begin
      ser_din = f[i];
      cyc(6);
      if (i < 24) rd = {rd[22:0], ser_dout};
      ser_clk = 1'b1;
      cyc(6);
      ser_clk = 1'b0;
    end
    cyc(6);
    ser_en = 1'b0;
    cyc(10);
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] x;
    frame(1'b0, a, d, x);
    if (a >= PUMP_OFFSET && a <= DETECTOR_OFFSET) regs[a - PUMP_OFFSET] = d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [23:0] x);
    frame(1'b1, a, 24'h00_0000, x);
  endtask

  task automatic chk_ports();
    logic [23:0] g;
    logic [23:0] h;
    g = {1'b0, leak_sink_on, leak_source_on, leak_magnitude, pump_source_gain, pump_sink_gain};
    h = {19'h0_0000, slip_guard_threshold, detector_reset_delay_sel};
    chk_word(g, {1'b0, regs[0][22:0]});
    chk_word(h, {19'h0_0000, regs[2][8:7], regs[2][2:0]});
    chk_bit(cal_self_test, regs[1][15]);
    chk_bit(cal_clock_too_fast, regs[1][14:13] == 2'h0);
  endtask

  // counts clk edges from the call; at stays -1 when no cal_done is seen
  task automatic watch(input int lim, output int at, output logic s, output logic dr);
    at = -1;
    s = 1'b0;
    dr = 1'b0;
    for (int i = 1; i <= lim; i++) begin
      @(posedge clk);
      #1;
      if (cal_done === 1'b1 && at < 0) at = i;
      s |= osc_link_strobe === 1'b1;
      dr |= osc_link_dropped === 1'b1;
    end
    @(negedge clk);
  endtask

  initial begin
    logic [23:0] x;
    logic [23:0] w;
    logic [31:0] r;
    int at;
    int e;
    logic s;
    logic dr;
    {sys_rst, ser_clk, ser_en, ser_din, cal_request} = 5'h01 << 4;
    {osc_link_request, detector_raise_in, detector_lower_in} = 3'h0;
    regs = '{{1'b0, 1'b1, 1'b0, 7'h00, 7'h64, 7'h64}, 24'h00_2205, 24'h0f_8061};
    cyc(20);
    sys_rst = 1'b0;
    cyc(4);
    for (int k = 0; k < 3; k++) begin
      rd(PUMP_OFFSET + 6'(k), x);
      chk_word(x, regs[k]);
    end
    chk_ports();
    for (int n = 0; n < 6; n++) begin
      r = rnd();
      wr(PUMP_OFFSET + 6'(n % 3), r[23:0]);
      rd(PUMP_OFFSET + 6'(n % 3), x);
      chk_word(x, r[23:0]);
      chk_ports();
    end
    wr(6'h0c, 24'hff_ffff);
    rd(6'h0c, x);
    chk_word(x, 24'h00_0000);
    chk_ports();
    wr(PUMP_OFFSET, {1'b0, 1'b0, 1'b1, 7'h0a, 7'h64, 7'h64});
    chk_ports();
    for (int j = 0; j < 16; j++) begin
      w = 24'h0f_8061;
      {w[10], w[9], w[6], w[5]} = 4'(j);
      wr(DETECTOR_OFFSET, w);
      r = rnd();
      detector_raise_in = r[0];
      detector_lower_in = r[1];
      cyc(8);
      chk_bit(pump_raise, (r[0] & w[5]) | w[9]);
      chk_bit(pump_lower, (r[1] & w[6]) | w[10]);
    end
    detector_raise_in = 1'b0;
    detector_lower_in = 1'b0;
    for (int c = 0; c < 4; c++) begin
      w = 24'h0f_8061;
      w[8:7] = 2'(c);
      wr(DETECTOR_OFFSET, w);
      detector_raise_in = 1'b1;
      // two sync edges, then one edge per counted cycle past the limit
      cyc(sl[c] + 2);
      chk_bit(slip_boost, 1'b0);
      cyc(1);
      chk_bit(slip_boost, c != 0);
      detector_raise_in = 1'b0;
      cyc(6);
    end
    for (int inh = 1; inh >= 0; inh--) begin
      w = 24'h00_2205;
      w[12] = 1'(inh);
      wr(AUTOCAL_OFFSET, w);
      osc_link_request = 1'b1;
      watch(40, at, s, dr);
      chk_bit(dr, inh == 1);
      chk_bit(s, inh == 0);
      osc_link_request = 1'b0;
      cyc(4);
    end
    for (int k = 0; k < 4; k++) begin
      w = 24'h00_2205;
      w[2:0] = 3'(cal_t[k]);
      w[14:13] = 2'(k);
      wr(AUTOCAL_OFFSET, w);
      chk_bit(cal_clock_too_fast, k == 0);
      e = exp_cal(cal_t[k], k);
      cal_request = 1'b1;
      watch(e + dv[k] + 40, at, s, dr);
      chk_bit(at >= e - dv[k] + 1 && at <= e, 1'b1);
      cal_request = 1'b0;
      cyc(4);
    end
    w[11] = 1'b1;
    wr(AUTOCAL_OFFSET, w);
    cal_request = 1'b1;
    watch(300, at, s, dr);
    chk_bit(at == -1, 1'b1);
    cal_request = 1'b0;
    cyc(4);
    wrap_up();
  end
endmodule
